// ===== fwr_map.vh
`ifndef FWR_MAP_VH
`define FWR_MAP_VH
// How it works
// - Sample four currents and four voltages every 1.25/1.04 ms, 16 per cycle.
// - Instantaneous records are capped by an adjustable length of 5 s at most.
// - Rms mode stores one value per period; records at most 80 s.
// - Eight records kept; each new fault updates them, no acknowledge needed.
// - Start from pickup, binary input, operator or serial interface.
// - Capture only when mode selects instantaneous or rms values.
// - Trigger select: save on pickup, save on trip, start on trip.
// - Record is pre-trigger, normal interval, then post interval after drop.
// - Maximum length 0.30 to 5.00 s, default 1.00 s, caps the normal interval only; pre-trigger comes on top.
// - Pre-trigger interval 0.05 to 0.60 s, default 0.20 s.
// - Post-trigger interval 0.05 to 0.50 s, default 0.10 s.
// - Durations are for 50 Hz; rms mode makes them sixteen times longer.
// - Manual capture triggers on edge, lasts its setting capped at maximum.
// - Infinite manual time lasts while the input is high, capped at maximum.
// - Limit alarm raised only after several consecutive crossings.
// - Only the undercurrent limit is active by default; it raises its alarm.
// - Each record carries pickup and trip traces beside the samples.

// Timing, in the unit named.
`define FWR_CLK_NS 4
`define FWR_SAMPLE50_NS 1250000
`define FWR_SAMPLE60_NS 1040000
`define FWR_LAST_PHASE 4'hF
`define FWR_UNIT_SHIFT 3

// Register byte offsets.
`define FWR_A_CTRL 8'h00
`define FWR_A_MAXLEN 8'h04
`define FWR_A_PRE 8'h08
`define FWR_A_POST 8'h0C
`define FWR_A_MANUAL 8'h10
`define FWR_A_ULIMIT 8'h14
`define FWR_A_STATUS 8'h18
`define FWR_A_MASK 8'h1C
`define FWR_A_INFO 8'h20
`define FWR_A_SLOTSEL 8'h24
`define FWR_A_SLOTSTART 8'h28
`define FWR_A_SLOTLEN 8'h2C
`define FWR_A_RDIDX 8'h30
`define FWR_A_RDCH 8'h34
`define FWR_A_RDDATA 8'h38

// Control fields and codes.
`define FWR_CTRL_MODE 1:0
`define FWR_CTRL_TRIG 3:2
`define FWR_CTRL_F60 4
`define FWR_CTRL_SWTRIG 5
`define FWR_CTRL_UEN 6
`define FWR_CTRL_RESET 7'h41
`define FWR_MODE_INST 2'h1
`define FWR_MODE_RMS 2'h2
`define FWR_TRIG_SAVE_PU 2'h0
`define FWR_TRIG_SAVE_TRIP 2'h1
`define FWR_TRIG_START_TRIP 2'h2

// Durations in 10 ms steps: minimum, maximum, reset value.
`define FWR_MAX_MIN 9'h01E
`define FWR_MAX_MAX 9'h1F4
`define FWR_MAX_DEF 9'h064
`define FWR_PRE_MIN 9'h005
`define FWR_PRE_MAX 9'h03C
`define FWR_PRE_DEF 9'h014
`define FWR_POST_MIN 9'h005
`define FWR_POST_MAX 9'h032
`define FWR_POST_DEF 9'h00A
`define FWR_MAN_MIN 9'h00A
`define FWR_MAN_DEF 9'h032
`define FWR_MAN_INF 9'h000

// Limit monitor and status bits.
`define FWR_ULIMIT_DEF 16'h0100
`define FWR_REPEAT 2'h3
`define FWR_ST_START 0
`define FWR_ST_SAVED 1
`define FWR_ST_ALARM 2
`define FWR_SLOTS 4'h8
`endif

// ===== fwr_recorder.v
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "fwr_map.vh"
module fwr_recorder #(
   parameter SAMPLE50 = `FWR_SAMPLE50_NS / `FWR_CLK_NS,
   parameter SAMPLE60 = `FWR_SAMPLE60_NS / `FWR_CLK_NS
) (
   // System.
   input wire clk_sys,
   input wire reset_n,
   // Wishbone slave.
   input wire [7:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   input wire [3:0] wb_sel_i,
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Analogue samples, same clock domain.
   input wire [127:0] sampleData,
   input wire [15:0] rmsCurrent,
   // Pins from protection and binary inputs.
   input wire pickup,
   input wire trip,
   input wire manualCapture,
   // Indications.
   output reg recordingStartedFlag,
   output reg undercurrentAlarm,
   output reg irq
);

   localparam ST_IDLE = 4'b0001;
   localparam ST_RUN = 4'b0010;
   localparam ST_POST = 4'b0100;
   localparam ST_DONE = 4'b1000;

   // Out-of-range settings are pulled to the nearest limit.
   function [8:0] clamp;
      input [8:0] v;
      input [8:0] lo;
      input [8:0] hi;
      begin
         clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
      end
   endfunction

   // A 10 ms step is 8 frames at 50 Hz in instantaneous mode and 8
   // periods (160 ms) in rms mode, so one scale serves both.
   function [12:0] frames;
      input [8:0] v;
      begin
         frames = {1'b0, v, 3'h0};
      end
   endfunction

   reg [6:0] ctrl;
   reg [8:0] maxLen, preLen, postLen, manLen;
   reg [15:0] uLimit;
   reg [2:0] status, mask, slotSel;
   reg [12:0] rdIdx;
   reg [3:0] rdCh;
   reg swTrig;
   reg [129:0] mem [0:8191];
   reg [129:0] memQ;
   reg [12:0] wrPtr;
   reg [12:0] slotStart [0:7], slotLen [0:7];
   reg [2:0] slotPtr;
   reg [3:0] slotCount;
   reg [18:0] tickCnt;
   reg sampleTick;
   reg [3:0] phase;
   reg [2:0] pickSync, tripSync, binSync;
   reg [3:0] state;
   reg [12:0] startPtr, runCnt, postCnt;
   reg fromManual, fromBin, tripSeen;
   reg [1:0] crossCnt;
   reg [31:0] rdMux;
   reg crit;
   integer k;

   wire access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr = access & wb_we_i;
   wire [1:0] mode = ctrl[`FWR_CTRL_MODE];
   wire [1:0] trigSel = ctrl[`FWR_CTRL_TRIG];
   wire enabled = (mode == `FWR_MODE_INST) |
      (mode == `FWR_MODE_RMS);
   wire periodTick = sampleTick & (phase == `FWR_LAST_PHASE);
   wire frameTick = enabled & ((mode == `FWR_MODE_INST) ?
      sampleTick : periodTick);
   wire pickS = pickSync[1];
   wire tripS = tripSync[1];
   wire binS = binSync[1];
   wire pickRise = pickS & ~pickSync[2];
   wire tripRise = tripS & ~tripSync[2];
   wire binRise = binS & ~binSync[2];
   wire manRise = binRise | swTrig;
   wire autoRise = (trigSel == `FWR_TRIG_START_TRIP) ?
      tripRise : pickRise;
   wire startRec = enabled & (state == ST_IDLE) &
      (manRise | autoRise);
   wire [12:0] maxFrames = frames(maxLen);
   wire manInf = (manLen == `FWR_MAN_INF);
   wire [12:0] manFrames = (manInf | (manLen > maxLen)) ?
      maxFrames : frames(manLen);
   wire keep = fromManual | (trigSel != `FWR_TRIG_SAVE_TRIP) | tripSeen;
   wire alarmNow = crossCnt == `FWR_REPEAT;
   wire [2:0] events;
   // Byte lanes of a bus write; unselected lanes keep their old bits.
   wire [31:0] lanes = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
      {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [31:0] wval = wb_dat_i & lanes;
   wire [8:0] manNew = (manLen & ~lanes[8:0]) | wval[8:0];

   assign events = {alarmNow & ~undercurrentAlarm,
      (state == ST_DONE) & keep, startRec};

   // Sample clock: period picked by the system frequency bit.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         tickCnt <= 19'h0;
         sampleTick <= 1'b0;
         phase <= 4'h0;
      end else begin
         if (tickCnt >= (ctrl[`FWR_CTRL_F60] ? SAMPLE60 - 1 :
               SAMPLE50 - 1)) begin
            tickCnt <= 19'h0;
            sampleTick <= 1'b1;
         end else begin
            tickCnt <= tickCnt + 19'h1;
            sampleTick <= 1'b0;
         end
         if (sampleTick)
            phase <= phase + 4'h1;
      end
   end

   // Pins pass two flops; the third keeps the previous level for edges.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pickSync <= 3'h0;
         tripSync <= 3'h0;
         binSync <= 3'h0;
      end else begin
         pickSync <= {pickSync[1:0], pickup};
         tripSync <= {tripSync[1:0], trip};
         binSync <= {binSync[1:0], manualCapture};
      end
   end

   // Ring buffer runs free, so the pre-trigger span is always there.
   always @(posedge clk_sys) begin
      if (frameTick)
         mem[wrPtr] <= {tripS, pickS, sampleData};
      memQ <= mem[rdIdx];
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n)
         wrPtr <= 13'h0;
      else if (frameTick)
         wrPtr <= wrPtr + 13'h1;
   end

   // Save criterion of the record under way.
   always @* begin
      crit = 1'b0;
      if (fromManual)
         crit = (manInf & fromBin) ? binS : (runCnt < manFrames);
      else if (trigSel == `FWR_TRIG_START_TRIP)
         crit = tripS;
      else
         crit = pickS;
   end

   // Record sequencer; a record longer than the ring overwrites itself,
   // so the memory is sized for the longest pre, normal and post spans.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         startPtr <= 13'h0;
         runCnt <= 13'h0;
         postCnt <= 13'h0;
         fromManual <= 1'b0;
         fromBin <= 1'b0;
         tripSeen <= 1'b0;
         slotPtr <= 3'h0;
         slotCount <= 4'h0;
         for (k = 0; k < 8; k = k + 1) begin
            slotStart[k] <= 13'h0;
            slotLen[k] <= 13'h0;
         end
      end else begin
         case (state)
            ST_IDLE: begin
               if (startRec) begin
                  state <= ST_RUN;
                  startPtr <= wrPtr - frames(preLen);
                  runCnt <= 13'h0;
                  fromManual <= manRise;
                  fromBin <= binRise;
                  tripSeen <= tripS;
               end
            end
            ST_RUN: begin
               if (tripS)
                  tripSeen <= 1'b1;
               if (!enabled)
                  state <= ST_IDLE;
               else if (runCnt >= maxFrames)
                  state <= ST_DONE;
               else if (!crit) begin
                  state <= ST_POST;
                  postCnt <= 13'h0;
               end else if (frameTick)
                  runCnt <= runCnt + 13'h1;
            end
            ST_POST: begin
               if (tripS)
                  tripSeen <= 1'b1;
               if (!enabled)
                  state <= ST_IDLE;
               else if (postCnt >= frames(postLen))
                  state <= ST_DONE;
               else if (frameTick)
                  postCnt <= postCnt + 13'h1;
            end
            ST_DONE: begin
               state <= ST_IDLE;
               if (keep) begin
                  slotStart[slotPtr] <= startPtr;
                  slotLen[slotPtr] <= wrPtr - startPtr;
                  slotPtr <= slotPtr + 3'h1;
                  if (slotCount != `FWR_SLOTS)
                     slotCount <= slotCount + 4'h1;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Undercurrent monitor, judged once per period on the rms value.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         crossCnt <= 2'h0;
         undercurrentAlarm <= 1'b0;
      end else begin
         if (!ctrl[`FWR_CTRL_UEN])
            crossCnt <= 2'h0;
         else if (periodTick) begin
            if (rmsCurrent >= uLimit)
               crossCnt <= 2'h0;
            else if (!alarmNow)
               crossCnt <= crossCnt + 2'h1;
         end
         undercurrentAlarm <= alarmNow;
      end
   end

   // Register writes; a hardware event outweighs a clear in one cycle.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ctrl <= `FWR_CTRL_RESET;
         maxLen <= `FWR_MAX_DEF;
         preLen <= `FWR_PRE_DEF;
         postLen <= `FWR_POST_DEF;
         manLen <= `FWR_MAN_DEF;
         uLimit <= `FWR_ULIMIT_DEF;
         status <= 3'h0;
         mask <= 3'h0;
         slotSel <= 3'h0;
         rdIdx <= 13'h0;
         rdCh <= 4'h0;
         swTrig <= 1'b0;
      end else begin
         swTrig <= 1'b0;
         if (wr && wb_adr_i == `FWR_A_CTRL) begin
            ctrl <= ((ctrl & ~lanes[6:0]) | wval[6:0]) & 7'h5F;
            swTrig <= wval[`FWR_CTRL_SWTRIG];
         end else if (wr && wb_adr_i == `FWR_A_MAXLEN)
            maxLen <= clamp((maxLen & ~lanes[8:0]) | wval[8:0],
               `FWR_MAX_MIN, `FWR_MAX_MAX);
         else if (wr && wb_adr_i == `FWR_A_PRE)
            preLen <= clamp((preLen & ~lanes[8:0]) | wval[8:0],
               `FWR_PRE_MIN, `FWR_PRE_MAX);
         else if (wr && wb_adr_i == `FWR_A_POST)
            postLen <= clamp((postLen & ~lanes[8:0]) | wval[8:0],
               `FWR_POST_MIN, `FWR_POST_MAX);
         else if (wr && wb_adr_i == `FWR_A_MANUAL) begin
            if (manNew == `FWR_MAN_INF)
               manLen <= `FWR_MAN_INF;
            else
               manLen <= clamp(manNew, `FWR_MAN_MIN, `FWR_MAX_MAX);
         end else if (wr && wb_adr_i == `FWR_A_ULIMIT)
            uLimit <= (uLimit & ~lanes[15:0]) | wval[15:0];
         else if (wr && wb_adr_i == `FWR_A_MASK)
            mask <= (mask & ~lanes[2:0]) | wval[2:0];
         else if (wr && wb_adr_i == `FWR_A_SLOTSEL)
            slotSel <= (slotSel & ~lanes[2:0]) | wval[2:0];
         else if (wr && wb_adr_i == `FWR_A_RDIDX)
            rdIdx <= (rdIdx & ~lanes[12:0]) | wval[12:0];
         else if (wr && wb_adr_i == `FWR_A_RDCH)
            rdCh <= (rdCh & ~lanes[3:0]) | wval[3:0];
         if (wr && wb_adr_i == `FWR_A_STATUS)
            status <= (status & ~wval[2:0]) | events;
         else
            status <= status | events;
      end
   end

   // Read multiplexer; unmapped addresses read as zero.
   always @* begin
      rdMux = 32'h0;
      if (wb_adr_i == `FWR_A_CTRL)
         rdMux = {25'h0, ctrl};
      else if (wb_adr_i == `FWR_A_MAXLEN)
         rdMux = {23'h0, maxLen};
      else if (wb_adr_i == `FWR_A_PRE)
         rdMux = {23'h0, preLen};
      else if (wb_adr_i == `FWR_A_POST)
         rdMux = {23'h0, postLen};
      else if (wb_adr_i == `FWR_A_MANUAL)
         rdMux = {23'h0, manLen};
      else if (wb_adr_i == `FWR_A_ULIMIT)
         rdMux = {16'h0, uLimit};
      else if (wb_adr_i == `FWR_A_STATUS)
         rdMux = {29'h0, status};
      else if (wb_adr_i == `FWR_A_MASK)
         rdMux = {29'h0, mask};
      else if (wb_adr_i == `FWR_A_INFO)
         rdMux = {20'h0, state, 1'b0, slotPtr - 3'h1, slotCount};
      else if (wb_adr_i == `FWR_A_SLOTSEL)
         rdMux = {29'h0, slotSel};
      else if (wb_adr_i == `FWR_A_SLOTSTART)
         rdMux = {19'h0, slotStart[slotSel]};
      else if (wb_adr_i == `FWR_A_SLOTLEN)
         rdMux = {19'h0, slotLen[slotSel]};
      else if (wb_adr_i == `FWR_A_RDIDX)
         rdMux = {19'h0, rdIdx};
      else if (wb_adr_i == `FWR_A_RDCH)
         rdMux = {28'h0, rdCh};
      else if (wb_adr_i == `FWR_A_RDDATA) begin
         if (rdCh[3])
            rdMux = {30'h0, memQ[129:128]};
         else
            rdMux = {16'h0, memQ[rdCh[2:0]*16 +: 16]};
      end
   end

   // Bus answer one cycle after the request, then dropped for a cycle.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         irq <= 1'b0;
         recordingStartedFlag <= 1'b0;
      end else begin
         wb_ack_o <= access;
         if (access & ~wb_we_i)
            wb_dat_o <= rdMux;
         irq <= |(status & mask);
         recordingStartedFlag <= (state != ST_IDLE) | startRec;
      end
   end

endmodule

// ===== fwr_recorder_monitor.sv
`timescale 1ns/1ps
`include "fwr_map.vh"
module fwr_recorder_monitor #(
   parameter SAMPLE50 = 20,
   parameter SAMPLE60 = 16
) (
   // System.
   input wire clk_sys,
   input wire reset_n,
   // Bus.
   input wire wb_we_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire wb_ack_o,
   // Pins and indications.
   input wire [15:0] rmsCurrent,
   input wire pickup,
   input wire trip,
   input wire manualCapture,
   input wire recordingStartedFlag,
   input wire undercurrentAlarm,
   input wire irq
);
   localparam [15:0] ULIM = `FWR_ULIMIT_DEF;
   // Two periods at the faster rate is the least time before a third low.
   localparam int LOWMIN = 32 * SAMPLE60;
   reg [7:0] wrHist;
   reg [31:0] lowCnt;
   // A recent write may start a record or switch the alarm off.
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wrHist <= 8'h00;
         lowCnt <= 32'h0;
      end else begin
         wrHist <= {wrHist[6:0], wb_ack_o & wb_we_i};
         lowCnt <= (rmsCurrent < ULIM) ? lowCnt + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ack_latency_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered in one cycle");
   ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property (
      wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("ack without request");
   rdata_hold_a: assert property (
      $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
      else $error("read data moved outside a read answer");
   start_cause_a: assert property ($rose(recordingStartedFlag) |->
      $past(pickup, 3) || $past(trip, 3) || $past(manualCapture, 3)
      || (|wrHist))
      else $error("record started without a trigger");
   alarm_rise_a: assert property (
      $rose(undercurrentAlarm) |-> lowCnt >= LOWMIN)
      else $error("alarm raised before repeated low periods");
   alarm_fall_a: assert property (
      $fell(undercurrentAlarm) |-> rmsCurrent >= ULIM || (|wrHist))
      else $error("alarm dropped while current low");
   irq_clear_a: assert property (
      $fell(irq) |-> wb_ack_o || $past(wb_ack_o))
      else $error("interrupt dropped without a write");
   cover property ($rose(recordingStartedFlag));
   cover property ($rose(undercurrentAlarm));
   cover property ($rose(irq));
endmodule
bind fwr_recorder fwr_recorder_monitor #(
   .SAMPLE50(SAMPLE50), .SAMPLE60(SAMPLE60)) mon (
   .clk_sys(clk_sys), .reset_n(reset_n), .wb_we_i(wb_we_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .rmsCurrent(rmsCurrent), .pickup(pickup),
   .trip(trip), .manualCapture(manualCapture),
   .recordingStartedFlag(recordingStartedFlag),
   .undercurrentAlarm(undercurrentAlarm), .irq(irq));

// ===== fwr_partner.sv
`timescale 1ns/1ps
module fwr_partner (
   // Clock.
   input wire clk_sys,
   // Protection and binary input pins.
   output logic pickup,
   output logic trip,
   output logic manualCapture,
   // Analogue stream.
   output logic [127:0] sampleData,
   output logic [15:0] rmsCurrent
);
   // Pins idle low; current starts well above the limit.
   initial begin
      pickup = 1'b0;
      trip = 1'b0;
      manualCapture = 1'b0;
      sampleData = 128'h0;
      rmsCurrent = 16'hFFFF;
   end
   // Each channel ramps so that no two frames carry the same word.
   always @(posedge clk_sys) begin
      sampleData <= sampleData + {8{16'h0101}};
   end
   // Pickup and trip change only just after an edge.
   task automatic pins(input logic p, t, m);
      @(posedge clk_sys);
      pickup <= p;
      trip <= t;
      manualCapture <= m;
   endtask
   task automatic level(input logic [15:0] v);
      @(posedge clk_sys);
      rmsCurrent <= v;
   endtask
endmodule

// ===== fwr_recorder_tb.sv
`timescale 1ns/1ps
`include "fwr_map.vh"
module fwr_recorder_tb;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} fwr_row_t;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic cyc = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rd;
   wire [31:0] dato;
   wire [127:0] smp;
   wire [15:0] rms;
   wire ack, pickup, trip, manCap, flag, alarm, irq;
   int miscompares = 0;
   int n_compared = 0;
   int cycles = 0;
   int nRec = 0;
   // Reads, then write-and-readback; the last rows leave short durations.
   fwr_row_t rows[17] = '{
      '{1'b0, `FWR_A_CTRL, 32'h0, 32'h41},
      '{1'b0, `FWR_A_MAXLEN, 32'h0, 32'h64},
      '{1'b0, `FWR_A_PRE, 32'h0, 32'h14},
      '{1'b0, `FWR_A_POST, 32'h0, 32'h0A},
      '{1'b0, `FWR_A_MANUAL, 32'h0, 32'h32},
      '{1'b0, `FWR_A_ULIMIT, 32'h0, 32'h100},
      '{1'b0, `FWR_A_MASK, 32'h0, 32'h0},
      '{1'b1, 8'h3C, 32'h5, 32'h0},
      '{1'b1, `FWR_A_MAXLEN, 32'h3FF, 32'h1F4},
      '{1'b1, `FWR_A_MAXLEN, 32'h1, 32'h1E},
      '{1'b1, `FWR_A_PRE, 32'hFF, 32'h3C},
      '{1'b1, `FWR_A_PRE, 32'h0, 32'h5},
      '{1'b1, `FWR_A_POST, 32'hFF, 32'h32},
      '{1'b1, `FWR_A_POST, 32'h0, 32'h5},
      '{1'b1, `FWR_A_MANUAL, 32'h3FF, 32'h1F4},
      '{1'b1, `FWR_A_MANUAL, 32'h1, 32'h0A},
      '{1'b1, `FWR_A_MASK, 32'h7, 32'h7}};
   fwr_partner P (.clk_sys(clk_sys), .pickup(pickup), .trip(trip),
      .manualCapture(manCap), .sampleData(smp), .rmsCurrent(rms));
   // Short sample periods keep every record within a few thousand cycles.
   fwr_recorder #(.SAMPLE50(4), .SAMPLE60(3)) DUT (.clk_sys(clk_sys),
      .reset_n(reset_n), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF),
      .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(dato),
      .wb_ack_o(ack), .sampleData(smp), .rmsCurrent(rms), .pickup(pickup),
      .trip(trip), .manualCapture(manCap), .recordingStartedFlag(flag),
      .undercurrentAlarm(alarm), .irq(irq));
   // Clock, and a ceiling on run length in case a wait hangs.
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         miscompares++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (miscompares == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask
   // One classic cycle; the request stands until ack is sampled high.
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge clk_sys);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_sys); while (ack !== 1'b1);
      rd = dato;
      cyc <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), e, rd);
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic pulse(input logic p, t, m, input int n);
      P.pins(p, t, m);
      wt(n);
      P.pins(1'b0, 1'b0, 1'b0);
   endtask
   // A record must still run after hi cycles and be over by lo.
   task automatic span(input int hi, input int lo);
      wt(hi);
      chk("record running", 32'h1, {31'h0, flag});
      for (int i = hi; i < lo && flag === 1'b1; i++) wt(1);
      chk("record ended", 32'h0, {31'h0, flag});
   endtask
   // Polls and clears status the way the station would after a fault.
   task automatic done(input logic [31:0] e);
      rdchk(`FWR_A_STATUS, e);
      chk("irq", 32'h1, {31'h0, irq});
      wb(1'b1, `FWR_A_STATUS, 32'h7);
      wt(2);
      chk("irq clear", 32'h0, {31'h0, irq});
      if (e[1]) nRec++;
   endtask
   // Table first, then records in every trigger and capture mode.
   initial begin
      wt(10);
      reset_n <= 1'b1;
      wt(1);
      foreach (rows[i]) begin
         if (rows[i].w) wb(1'b1, rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].e);
      end
      pulse(1'b1, 1'b0, 1'b0, 50);
      span(120, 220);
      done(3);
      wb(1'b1, `FWR_A_CTRL, 32'h45);
      pulse(1'b1, 1'b0, 1'b0, 50);
      span(120, 220);
      done(1);
      pulse(1'b1, 1'b1, 1'b0, 50);
      span(120, 220);
      done(3);
      // The second slot holds this record; two frames past time zero
      // both marks must still be set.
      wb(1'b1, `FWR_A_SLOTSEL, 32'h1);
      wb(1'b0, `FWR_A_SLOTSTART, 32'h0);
      wb(1'b1, `FWR_A_RDIDX, rd + 32'h2A);
      wb(1'b1, `FWR_A_RDCH, 32'h8);
      rdchk(`FWR_A_RDDATA, 32'h3);
      wb(1'b1, `FWR_A_CTRL, 32'h49);
      pulse(1'b1, 1'b0, 1'b0, 20);
      chk("no start", 32'h0, {31'h0, flag});
      pulse(1'b1, 1'b1, 1'b0, 50);
      span(120, 220);
      done(3);
      wb(1'b1, `FWR_A_CTRL, 32'h41);
      P.pins(1'b1, 1'b0, 1'b0);
      span(250, 1100);
      P.pins(1'b0, 1'b0, 1'b0);
      done(3);
      pulse(1'b0, 1'b0, 1'b1, 10);
      span(400, 600);
      done(3);
      wb(1'b1, `FWR_A_MANUAL, 32'h0);
      pulse(1'b0, 1'b0, 1'b1, 100);
      span(100, 220);
      done(3);
      wb(1'b1, `FWR_A_CTRL, 32'h61);
      span(500, 1300);
      done(3);
      wb(1'b1, `FWR_A_CTRL, 32'h40);
      pulse(1'b1, 1'b0, 1'b0, 20);
      chk("mode off", 32'h0, {31'h0, flag});
      rdchk(`FWR_A_STATUS, 32'h0);
      wb(1'b1, `FWR_A_CTRL, 32'h42);
      pulse(1'b1, 1'b0, 1'b0, 50);
      span(2000, 2800);
      done(3);
      rdchk(`FWR_A_INFO, 32'h178);
      chk("eight kept", nRec, rd & 32'hF);
      wb(1'b1, `FWR_A_CTRL, 32'h51);
      P.level(16'h0010);
      wt(90);
      chk("alarm early", 32'h0, {31'h0, alarm});
      wt(150);
      chk("alarm", 32'h1, {31'h0, alarm});
      done(4);
      P.level(16'hFFFF);
      wt(100);
      chk("alarm off", 32'h0, {31'h0, alarm});
      wb(1'b1, `FWR_A_CTRL, 32'h61);
      span(500, 1300);
      done(3);
      rdchk(`FWR_A_INFO, 32'h108);
      chk("oldest reused", 32'h08, rd & 32'h7F);
      wb(1'b1, `FWR_A_CTRL, 32'h61);
      wt(20);
      reset_n <= 1'b0;
      wt(3);
      reset_n <= 1'b1;
      wt(1);
      chk("reset stop", 32'h0, {31'h0, flag});
      rdchk(`FWR_A_CTRL, 32'h41);
      rdchk(`FWR_A_MAXLEN, 32'h64);
      tally_and_finish();
   end
endmodule
